// *** rec_pkg.sv ***
// Purpose: shared constants and types for the remap extended capability bank
// Assumes: 32-bit register port, 64-bit capability image split in two words
// Notes:   offsets below are local to this bank
package rec_pkg;

  // register offsets
  localparam logic [7:0] CAP_LO_OFS = 8'h00;
  localparam logic [7:0] CAP_HI_OFS = 8'h04;
  localparam logic [7:0] CTRL_OFS   = 8'h08;
  localparam logic [7:0] STAT_OFS   = 8'h0c;
  localparam logic [7:0] ERRCNT_OFS = 8'h10;
  localparam logic [7:0] REQCNT_OFS = 8'h14;

  // capability bit positions in the 64-bit image
  localparam int PERF_MON_BIT    = 51;
  localparam int RSVD_HI_BIT     = 50;
  localparam int DEF_PASID_BIT   = 49;
  localparam int WALK_COH_BIT    = 48;
  localparam int FIRST_STG_BIT   = 47;
  localparam int SECOND_STG_BIT  = 46;
  localparam int SS_AD_BIT       = 45;
  localparam int VIRT_CMD_BIT    = 44;
  localparam int SCALABLE_BIT    = 43;
  localparam int PAGE_DRAIN_BIT  = 42;
  localparam int INV_THROT_BIT   = 41;
  localparam int PASID_SUP_BIT   = 40;
  localparam int PASID_SZ_LSB    = 35;
  localparam int PASID_SZ_W      = 5;
  localparam int EXT_ACC_BIT     = 34;
  localparam int NO_WRITE_BIT    = 33;
  localparam int RSVD_LO_BIT     = 32;
  localparam int SUPERVISOR_BIT  = 31;

  // control and status fields
  localparam int CTRL_CHK_EN_BIT = 0;
  localparam int CTRL_CNT_EN_BIT = 1;
  localparam logic [1:0] CTRL_RESET = 2'h3;
  localparam int STAT_PASID_BIT  = 0;
  localparam int STAT_XLATE_BIT  = 1;
  localparam int STAT_SUPER_BIT  = 2;
  localparam int STAT_W          = 3;
  localparam int CNT_W           = 16;

  // translation type codes
  localparam logic [2:0] XLATE_FIRST  = 3'h1;
  localparam logic [2:0] XLATE_SECOND = 3'h2;

  typedef struct packed {
    logic                  perfMonitorSupport;
    logic                  defaultPasidFieldSupport;
    logic                  scalableWalkCoherencySupport;
    logic                  firstStageSupport;
    logic                  secondStageSupport;
    logic                  secondStageAdSupport;
    logic                  virtualCommandSupport;
    logic                  scalableModeSupport;
    logic                  pageDrainSupport;
    logic                  tlbInvalThrottleSupport;
    logic                  pasidSupport;
    logic [PASID_SZ_W-1:0] pasidSizeField;
    logic                  extendedAccessedSupport;
    logic                  noWriteFlagSupport;
    logic                  supervisorRequestSupport;
  } rec_cap_s;

  typedef struct packed {
    logic                  enhancedCommandSupport;
    logic                  queuedInvalidationSupport;
    logic                  passthroughSupport;
    logic                  deviceTlbSupport;
  } rec_dep_s;

endpackage

// *** rec_cap_resolve.sv ***
// Purpose: ties dependent capability bits to zero when their base feature is absent
// Assumes: raw values are implementation constants
// Notes:   purely combinational
`timescale 1ns/10ps
`default_nettype none
module rec_cap_resolve (
  input  wire rec_pkg::rec_cap_s capRaw,
  input  wire rec_pkg::rec_dep_s dep,
  output rec_pkg::rec_cap_s      capOut
);

  logic scalable_mode_support;

  assign scalable_mode_support = capRaw.scalableModeSupport & dep.queuedInvalidationSupport
              & (capRaw.firstStageSupport | capRaw.secondStageSupport
                 | dep.passthroughSupport);

  always_comb begin
    capOut = capRaw;
    capOut.scalableModeSupport = scalable_mode_support;
    capOut.perfMonitorSupport = capRaw.perfMonitorSupport & dep.enhancedCommandSupport;
    capOut.defaultPasidFieldSupport = capRaw.defaultPasidFieldSupport & scalable_mode_support;
    capOut.scalableWalkCoherencySupport = capRaw.scalableWalkCoherencySupport & scalable_mode_support;
    capOut.firstStageSupport = capRaw.firstStageSupport & scalable_mode_support;
    capOut.secondStageSupport = capRaw.secondStageSupport;
    capOut.secondStageAdSupport = capRaw.secondStageAdSupport
                                & capRaw.scalableWalkCoherencySupport & scalable_mode_support;
    capOut.virtualCommandSupport = 1'b0;
    capOut.pageDrainSupport = capRaw.pageDrainSupport & dep.deviceTlbSupport;
    capOut.tlbInvalThrottleSupport = capRaw.tlbInvalThrottleSupport & dep.deviceTlbSupport;
    capOut.pasidSupport = capRaw.pasidSupport & scalable_mode_support;
    capOut.pasidSizeField = scalable_mode_support ? capRaw.pasidSizeField : '0;
    capOut.extendedAccessedSupport = capRaw.extendedAccessedSupport
                                   & capRaw.firstStageSupport & scalable_mode_support
                                   & capRaw.scalableWalkCoherencySupport;
    capOut.noWriteFlagSupport = capRaw.noWriteFlagSupport & dep.deviceTlbSupport;
    capOut.supervisorRequestSupport = capRaw.supervisorRequestSupport & scalable_mode_support;
  end

endmodule
`default_nettype wire

// *** rec_ext_cap_top.sv ***
// Purpose: extended capability bits 51..31 with register port and request qualifiers
// Assumes: requests and register strobes synchronous to clk_sys
// Notes:   capability image is constant; writes to it are dropped
`timescale 1ns/10ps
`default_nettype none
// What this block does
// - performance monitoring bit 51 is zero without enhanced command support.
// - without bit 49 the context default pasid is replaced by zero.
// - bit 49 reports default pasid field support, zero without scalable mode.
// - walk snoop follows entry only when bit 48 set; zero without scalable.
// - bit 47 reports first stage type code accepted; zero without scalable.
// - bit 46 reports second stage type code accepted.
// - bit 45 accessed dirty support, zero without walk coherency.
// - bit 44 virtual command support always reads zero in hardware.
// - bit 43 scalable mode, needs queued invalidation and some translation kind.
// - bit 42 page drain support, zero without device tlb.
// - bit 41 invalidation throttle, zero without device tlb.
// - bit 40 pasid requests accepted, zero without scalable mode.
// - bits 39:35 hold N, pasids of N+1 bits accepted.
// - a pasid wider than the advertised size is an error.
// - pasid size field reads zero without scalable mode.
// - bit 34 extended accessed, needs first stage and walk coherency.
// - without bit 33 the no-write flag is treated as clear.
// - no-write capability reads zero without device tlb.
// - bit 31 supervisor requests, zero without scalable mode.
module rec_ext_cap_top #(
  parameter int          PASID_W         = 20,
  parameter logic        PERF_MON_RAW    = 1'b1,
  parameter logic        DEF_PASID_RAW   = 1'b1,
  parameter logic        WALK_COH_RAW    = 1'b1,
  parameter logic        FIRST_STG_RAW   = 1'b1,
  parameter logic        SECOND_STG_RAW  = 1'b1,
  parameter logic        SS_AD_RAW       = 1'b1,
  parameter logic        SCALABLE_RAW    = 1'b1,
  parameter logic        PAGE_DRAIN_RAW  = 1'b1,
  parameter logic        INV_THROT_RAW   = 1'b1,
  parameter logic        PASID_SUP_RAW   = 1'b1,
  parameter logic [4:0]  PASID_SZ_RAW    = 5'h13,
  parameter logic        EXT_ACC_RAW     = 1'b1,
  parameter logic        NO_WRITE_RAW    = 1'b1,
  parameter logic        SUPERVISOR_RAW  = 1'b1,
  parameter logic        ENH_CMD_SUP     = 1'b1,
  parameter logic        QUEUED_INV_SUP  = 1'b1,
  parameter logic        PASSTHRU_SUP    = 1'b1,
  parameter logic        DEV_TLB_SUP     = 1'b1
) (
  input  wire logic               clk_sys,
  input  wire logic               rst,
  input  wire logic [7:0]         regAddr,
  input  wire logic [31:0]        regWrData,
  input  wire logic               regWr,
  input  wire logic               regRd,
  output logic [31:0]             regRdData,
  input  wire logic               reqValid,
  input  wire logic               reqHasPasid,
  input  wire logic [PASID_W-1:0] reqPasid,
  input  wire logic               reqSupervisor,
  input  wire logic               reqNoWrite,
  input  wire logic [PASID_W-1:0] ctxDefaultPasid,
  input  wire logic               walkSnoopField,
  input  wire logic [2:0]         xlateTypeCode,
  output logic                    rspValid,
  output logic                    rspPasidErr,
  output logic                    rspXlateErr,
  output logic                    rspSuperErr,
  output logic [PASID_W-1:0]      rspDefaultPasid,
  output logic                    rspNoWrite,
  output logic                    rspWalkSnoop,
  output logic [63:0]             capImage
);

  rec_pkg::rec_cap_s capRaw;
  rec_pkg::rec_cap_s cap;
  rec_pkg::rec_dep_s dep;

  logic [63:0]             capWord;
  logic [PASID_W-1:0]      pasidOver;
  logic                    pasidErr;
  logic                    xlateErr;
  logic                    superErr;
  logic                    anyErr;
  logic                    chkEn;
  logic                    cntEn;
  logic                    wrCtrl;
  logic                    wrStat;
  logic                    wrErrCnt;
  logic                    wrReqCnt;
  logic [rec_pkg::STAT_W-1:0] statSet;

  logic [1:0]                 ctrl_ff;
  logic [rec_pkg::STAT_W-1:0] stat_ff;
  logic [rec_pkg::CNT_W-1:0]  errCnt_ff;
  logic [rec_pkg::CNT_W-1:0]  reqCnt_ff;
  logic [31:0]                rdData_ff;
  logic [31:0]                nxt_rdData;
  logic                       rspValid_ff;
  logic                       rspPasidErr_ff;
  logic                       rspXlateErr_ff;
  logic                       rspSuperErr_ff;
  logic [PASID_W-1:0]         rspDefaultPasid_ff;
  logic                       rspNoWrite_ff;
  logic                       rspWalkSnoop_ff;

  // implementation constants
  always_comb begin
    capRaw.perfMonitorSupport           = PERF_MON_RAW;
    capRaw.defaultPasidFieldSupport     = DEF_PASID_RAW;
    capRaw.scalableWalkCoherencySupport = WALK_COH_RAW;
    capRaw.firstStageSupport            = FIRST_STG_RAW;
    capRaw.secondStageSupport           = SECOND_STG_RAW;
    capRaw.secondStageAdSupport         = SS_AD_RAW;
    capRaw.virtualCommandSupport        = 1'b0;
    capRaw.scalableModeSupport          = SCALABLE_RAW;
    capRaw.pageDrainSupport             = PAGE_DRAIN_RAW;
    capRaw.tlbInvalThrottleSupport      = INV_THROT_RAW;
    capRaw.pasidSupport                 = PASID_SUP_RAW;
    capRaw.pasidSizeField               = PASID_SZ_RAW;
    capRaw.extendedAccessedSupport      = EXT_ACC_RAW;
    capRaw.noWriteFlagSupport           = NO_WRITE_RAW;
    capRaw.supervisorRequestSupport     = SUPERVISOR_RAW;
    dep.enhancedCommandSupport          = ENH_CMD_SUP;
    dep.queuedInvalidationSupport       = QUEUED_INV_SUP;
    dep.passthroughSupport              = PASSTHRU_SUP;
    dep.deviceTlbSupport                = DEV_TLB_SUP;
  end

  rec_cap_resolve u_resolve (
    .capRaw (capRaw),
    .dep    (dep),
    .capOut (cap)
  );

  // capability image; bits outside 51..31 are not ours and read zero
  always_comb begin
    capWord = '0;
    capWord[rec_pkg::PERF_MON_BIT]   = cap.perfMonitorSupport;
    capWord[rec_pkg::RSVD_HI_BIT]    = 1'b0;
    capWord[rec_pkg::RSVD_LO_BIT]    = 1'b0;
    capWord[rec_pkg::DEF_PASID_BIT]  = cap.defaultPasidFieldSupport;
    capWord[rec_pkg::WALK_COH_BIT]   = cap.scalableWalkCoherencySupport;
    capWord[rec_pkg::FIRST_STG_BIT]  = cap.firstStageSupport;
    capWord[rec_pkg::SECOND_STG_BIT] = cap.secondStageSupport;
    capWord[rec_pkg::SS_AD_BIT]      = cap.secondStageAdSupport;
    capWord[rec_pkg::VIRT_CMD_BIT]   = cap.virtualCommandSupport;
    capWord[rec_pkg::SCALABLE_BIT]   = cap.scalableModeSupport;
    capWord[rec_pkg::PAGE_DRAIN_BIT] = cap.pageDrainSupport;
    capWord[rec_pkg::INV_THROT_BIT]  = cap.tlbInvalThrottleSupport;
    capWord[rec_pkg::PASID_SUP_BIT]  = cap.pasidSupport;
    capWord[rec_pkg::PASID_SZ_LSB +: rec_pkg::PASID_SZ_W] = cap.pasidSizeField;
    capWord[rec_pkg::EXT_ACC_BIT]    = cap.extendedAccessedSupport;
    capWord[rec_pkg::NO_WRITE_BIT]   = cap.noWriteFlagSupport;
    capWord[rec_pkg::SUPERVISOR_BIT] = cap.supervisorRequestSupport;
  end

  assign capImage = capWord;

  genvar gi;
  generate
    for (gi = 0; gi < PASID_W; gi++) begin : g_over
      assign pasidOver[gi] = reqPasid[gi]
                           & (gi > int'(cap.pasidSizeField));
    end
  endgenerate

  assign chkEn = ctrl_ff[rec_pkg::CTRL_CHK_EN_BIT];
  assign cntEn = ctrl_ff[rec_pkg::CTRL_CNT_EN_BIT];

  assign pasidErr = reqHasPasid & ((|pasidOver) | ~cap.pasidSupport);

  assign xlateErr = ((xlateTypeCode == rec_pkg::XLATE_FIRST) & ~cap.firstStageSupport)
                  | ((xlateTypeCode == rec_pkg::XLATE_SECOND) & ~cap.secondStageSupport);

  assign superErr = reqSupervisor & ~cap.supervisorRequestSupport;

  assign anyErr = pasidErr | xlateErr | superErr;

  assign statSet = {superErr, xlateErr, pasidErr} & {rec_pkg::STAT_W{reqValid & chkEn}};

  // request qualification
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      rspValid_ff    <= 1'b0;
      rspPasidErr_ff <= 1'b0;
      rspXlateErr_ff <= 1'b0;
      rspSuperErr_ff <= 1'b0;
    end else begin
      rspValid_ff    <= reqValid;
      rspPasidErr_ff <= reqValid & chkEn & pasidErr;
      rspXlateErr_ff <= reqValid & chkEn & xlateErr;
      rspSuperErr_ff <= reqValid & chkEn & superErr;
    end
  end

  // effective request fields
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      rspDefaultPasid_ff <= '0;
      rspNoWrite_ff      <= 1'b0;
      rspWalkSnoop_ff    <= 1'b0;
    end else if (reqValid) begin
      rspDefaultPasid_ff <= cap.defaultPasidFieldSupport ? ctxDefaultPasid : '0;
      rspNoWrite_ff      <= cap.noWriteFlagSupport & reqNoWrite;
      rspWalkSnoop_ff    <= cap.scalableWalkCoherencySupport & walkSnoopField;
    end
  end

  assign rspValid        = rspValid_ff;
  assign rspPasidErr     = rspPasidErr_ff;
  assign rspXlateErr     = rspXlateErr_ff;
  assign rspSuperErr     = rspSuperErr_ff;
  assign rspDefaultPasid = rspDefaultPasid_ff;
  assign rspNoWrite      = rspNoWrite_ff;
  assign rspWalkSnoop    = rspWalkSnoop_ff;

  // register write decode
  // capability writes dropped
  assign wrCtrl   = regWr & (regAddr == rec_pkg::CTRL_OFS);
  assign wrStat   = regWr & (regAddr == rec_pkg::STAT_OFS);
  assign wrErrCnt = regWr & (regAddr == rec_pkg::ERRCNT_OFS);
  assign wrReqCnt = regWr & (regAddr == rec_pkg::REQCNT_OFS);

  // control register
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      ctrl_ff <= rec_pkg::CTRL_RESET;
    end else if (wrCtrl) begin
      ctrl_ff <= regWrData[1:0];
    end
  end

  // sticky error flags, write one to clear, set wins
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      stat_ff <= '0;
    end else if (wrStat) begin
      stat_ff <= (stat_ff & ~regWrData[rec_pkg::STAT_W-1:0]) | statSet;
    end else begin
      stat_ff <= stat_ff | statSet;
    end
  end

  // error counter, any write clears, saturates, a count with a clear loads one
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      errCnt_ff <= '0;
    end else if (reqValid & chkEn & anyErr & cntEn) begin
      if (wrErrCnt) begin
        errCnt_ff <= rec_pkg::CNT_W'(1);
      end else if (~&errCnt_ff) begin
        errCnt_ff <= errCnt_ff + rec_pkg::CNT_W'(1);
      end
    end else if (wrErrCnt) begin
      errCnt_ff <= '0;
    end
  end

  // request counter, same policy
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      reqCnt_ff <= '0;
    end else if (reqValid & cntEn) begin
      if (wrReqCnt) begin
        reqCnt_ff <= rec_pkg::CNT_W'(1);
      end else if (~&reqCnt_ff) begin
        reqCnt_ff <= reqCnt_ff + rec_pkg::CNT_W'(1);
      end
    end else if (wrReqCnt) begin
      reqCnt_ff <= '0;
    end
  end

  // read mux, unmapped reads zero
  always_comb begin
    nxt_rdData = '0;
    if (regRd) begin
      case (regAddr)
        rec_pkg::CAP_LO_OFS: nxt_rdData = capWord[31:0];
        rec_pkg::CAP_HI_OFS: nxt_rdData = capWord[63:32];
        rec_pkg::CTRL_OFS:   nxt_rdData = {30'h0, ctrl_ff};
        rec_pkg::STAT_OFS:   nxt_rdData = {29'h0, stat_ff};
        rec_pkg::ERRCNT_OFS: nxt_rdData = {16'h0, errCnt_ff};
        rec_pkg::REQCNT_OFS: nxt_rdData = {16'h0, reqCnt_ff};
        default:             nxt_rdData = '0;
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      rdData_ff <= '0;
    end else begin
      rdData_ff <= nxt_rdData;
    end
  end

  assign regRdData = rdData_ff;

endmodule
`default_nettype wire

// *** rec_ext_cap_props.sv ***
// Purpose: concurrent checks on the extended capability bank ports
// Assumes: one clock domain, synchronous active-high reset
// Notes:   error checks follow the check-enable bit tracked from ctrl writes
`timescale 1ns/10ps
`default_nettype none
module rec_ext_cap_props #(
  parameter int PASID_W = 20
) (
  input wire logic               clk_sys,
  input wire logic               rst,
  input wire logic [7:0]         regAddr,
  input wire logic [31:0]        regWrData,
  input wire logic               regWr,
  input wire logic               regRd,
  input wire logic [31:0]        regRdData,
  input wire logic               reqValid,
  input wire logic               reqHasPasid,
  input wire logic [PASID_W-1:0] reqPasid,
  input wire logic               reqNoWrite,
  input wire logic [PASID_W-1:0] ctxDefaultPasid,
  input wire logic               walkSnoopField,
  input wire logic               rspValid,
  input wire logic               rspPasidErr,
  input wire logic [PASID_W-1:0] rspDefaultPasid,
  input wire logic               rspNoWrite,
  input wire logic               rspWalkSnoop,
  input wire logic [63:0]        capImage
);
  logic chkEn_ff;
  logic pasidWide;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  // tracks the check-enable bit of ctrl
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      chkEn_ff <= 1'b1;
    end else if (regWr && regAddr == rec_pkg::CTRL_OFS) begin
      chkEn_ff <= regWrData[rec_pkg::CTRL_CHK_EN_BIT];
    end
  end

  assign pasidWide = (reqPasid >> (capImage[39:35] + 6'h01)) != '0;

  sequence s_rd_hi;
    regRd && regAddr == rec_pkg::CAP_HI_OFS;
  endsequence
  sequence s_rd_lo;
    regRd && regAddr == rec_pkg::CAP_LO_OFS;
  endsequence
  sequence s_pasid_req;
    reqValid && reqHasPasid && chkEn_ff;
  endsequence

  a_rd_hi_word: assert property (s_rd_hi |=> regRdData == capImage[63:32])
    else $error("high capability word read wrong");
  a_rd_lo_word: assert property (s_rd_lo |=> regRdData == capImage[31:0])
    else $error("low capability word read wrong");
  a_rd_idle_zero: assert property (!regRd |=> regRdData == '0)
    else $error("read data not zero outside read cycle");
  a_rsp_one_cycle: assert property (reqValid |=> rspValid ##1 (rspValid == $past(reqValid)))
    else $error("response strobe not one cycle after request");
  a_pasid_too_wide: assert property (s_pasid_req ##0 pasidWide |=> rspPasidErr)
    else $error("wide pasid not flagged");
  a_pasid_in_range: assert property (s_pasid_req ##0 !pasidWide ##0 capImage[40]
                                     |=> !rspPasidErr)
    else $error("pasid within size flagged");
  a_default_pasid: assert property (reqValid |=> rspDefaultPasid ==
    ($past(ctxDefaultPasid) & {PASID_W{capImage[rec_pkg::DEF_PASID_BIT]}}))
    else $error("default pasid not qualified by its bit");
  a_no_write_gate: assert property (reqValid |=> rspNoWrite ==
    ($past(reqNoWrite) & capImage[rec_pkg::NO_WRITE_BIT]))
    else $error("no-write flag not gated");
  a_walk_snoop_gate: assert property (reqValid |=> rspWalkSnoop ==
    ($past(walkSnoopField) & capImage[rec_pkg::WALK_COH_BIT]))
    else $error("walk snoop not gated");
  a_fixed_zero_bits: assert property (capImage[50] == 1'b0 && capImage[44] == 1'b0
                                      && capImage[32] == 1'b0)
    else $error("reserved or virtual command bit set");
  a_scalable_deps: assert property (!capImage[43] |-> capImage[49:47] == 3'h0
                                    && capImage[40:35] == 6'h00 && !capImage[31])
    else $error("scalable dependents set without scalable mode");
endmodule
bind rec_ext_cap_top rec_ext_cap_props #(.PASID_W(PASID_W)) props_u (
  .clk_sys(clk_sys), .rst(rst), .regAddr(regAddr), .regWrData(regWrData),
  .regWr(regWr), .regRd(regRd), .regRdData(regRdData), .reqValid(reqValid),
  .reqHasPasid(reqHasPasid), .reqPasid(reqPasid), .reqNoWrite(reqNoWrite),
  .ctxDefaultPasid(ctxDefaultPasid), .walkSnoopField(walkSnoopField),
  .rspValid(rspValid), .rspPasidErr(rspPasidErr), .rspDefaultPasid(rspDefaultPasid),
  .rspNoWrite(rspNoWrite), .rspWalkSnoop(rspWalkSnoop), .capImage(capImage)
);
`default_nettype wire

// *** remap_ext_capability_bits_tb.sv ***
// Purpose: self-checking bench for the extended capability bank
// Assumes: enhanced command and device tlb absent, other features present
// Notes:   pasid port widened to 24 bits so an oversize pasid can be sent
`timescale 1ns/10ps
`default_nettype none
module remap_ext_capability_bits_tb;
  localparam int   PW  = 24;
  localparam logic ENH = 1'b0;
  localparam logic DT  = 1'b0;
  logic          clk_sys = 1'b0;
  logic          rst = 1'b1;
  logic [7:0]    regAddr = 8'h00;
  logic [31:0]   regWrData = 32'h0;
  logic          regWr = 1'b0, regRd = 1'b0, reqValid = 1'b0, reqHasPasid = 1'b0;
  logic          reqSupervisor = 1'b0, reqNoWrite = 1'b0, walkSnoopField = 1'b0;
  logic [PW-1:0] reqPasid = '0, ctxDefaultPasid = '0;
  logic [2:0]    xlateTypeCode = 3'h0;
  logic [31:0]   regRdData, rdVal;
  logic          rspValid, rspPasidErr, rspXlateErr, rspSuperErr, rspNoWrite, rspWalkSnoop;
  logic [PW-1:0] rspDefaultPasid;
  logic [63:0]   capImage;
  logic [63:0]   capNoSm;
  int            nErrors = 0;
  int            comparisons = 0;

  always #20 clk_sys = ~clk_sys;

  rec_ext_cap_top #(.PASID_W(PW), .ENH_CMD_SUP(ENH), .DEV_TLB_SUP(DT)) dut_u (
    .clk_sys(clk_sys), .rst(rst), .regAddr(regAddr), .regWrData(regWrData),
    .regWr(regWr), .regRd(regRd), .regRdData(regRdData), .reqValid(reqValid),
    .reqHasPasid(reqHasPasid), .reqPasid(reqPasid), .reqSupervisor(reqSupervisor),
    .reqNoWrite(reqNoWrite), .ctxDefaultPasid(ctxDefaultPasid),
    .walkSnoopField(walkSnoopField), .xlateTypeCode(xlateTypeCode),
    .rspValid(rspValid), .rspPasidErr(rspPasidErr), .rspXlateErr(rspXlateErr),
    .rspSuperErr(rspSuperErr), .rspDefaultPasid(rspDefaultPasid),
    .rspNoWrite(rspNoWrite), .rspWalkSnoop(rspWalkSnoop), .capImage(capImage)
  );

  // queued invalidation absent, so scalable mode and its dependents drop out
  rec_ext_cap_top #(.PASID_W(PW), .QUEUED_INV_SUP(1'b0)) dutNoSm_u (
    .clk_sys(clk_sys), .rst(rst), .regAddr(regAddr), .regWrData(regWrData),
    .regWr(regWr), .regRd(regRd), .regRdData(), .reqValid(reqValid),
    .reqHasPasid(reqHasPasid), .reqPasid(reqPasid), .reqSupervisor(reqSupervisor),
    .reqNoWrite(reqNoWrite), .ctxDefaultPasid(ctxDefaultPasid),
    .walkSnoopField(walkSnoopField), .xlateTypeCode(xlateTypeCode),
    .rspValid(), .rspPasidErr(), .rspXlateErr(), .rspSuperErr(), .rspDefaultPasid(),
    .rspNoWrite(), .rspWalkSnoop(), .capImage(capNoSm)
  );

  task automatic chk(input string name, input logic [63:0] seen, input logic [63:0] exp);
    comparisons++;
    if (seen !== exp) begin
      nErrors++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic test_done;
    $display("comparisons %0d mismatches %0d", comparisons, nErrors);
    if (nErrors == 0 && comparisons > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    regWr <= 1'b1;
    regAddr <= a;
    regWrData <= d;
    @(posedge clk_sys);
    regWr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk_sys);
    regRd <= 1'b1;
    regAddr <= a;
    @(posedge clk_sys);
    regRd <= 1'b0;
    #1;
    d = regRdData;
  endtask

  task automatic req(input logic hp, input logic [PW-1:0] p, input logic [PW-1:0] ctx,
                     input logic [2:0] t, input logic sup, input logic nw, input logic ws);
    @(posedge clk_sys);
    reqValid <= 1'b1;
    reqHasPasid <= hp;
    reqPasid <= p;
    ctxDefaultPasid <= ctx;
    xlateTypeCode <= t;
    reqSupervisor <= sup;
    reqNoWrite <= nw;
    walkSnoopField <= ws;
    @(posedge clk_sys);
    reqValid <= 1'b0;
    #1;
  endtask

  initial begin
    repeat (3000) @(posedge clk_sys);
    nErrors++;
    test_done;
  end

  initial begin
    repeat (10) @(posedge clk_sys);
    rst <= 1'b0;
    // capability image fields
    chk("perf monitor", capImage[51], ENH);
    chk("default pasid", capImage[49], 1'b1);
    chk("walk coherency", capImage[48], 1'b1);
    chk("first stage", capImage[47], 1'b1);
    chk("second stage", capImage[46], 1'b1);
    chk("stage2 ad", capImage[45], 1'b1);
    chk("virtual cmd", capImage[44], 1'b0);
    chk("scalable", capImage[43], 1'b1);
    chk("page drain", capImage[42], DT);
    chk("inval throttle", capImage[41], DT);
    chk("pasid support", capImage[40], 1'b1);
    chk("pasid size", capImage[39:35], 5'h13);
    chk("ext accessed", capImage[34], 1'b1);
    chk("no write cap", capImage[33], DT);
    chk("reserved", {capImage[50], capImage[32]}, 2'h0);
    chk("supervisor", capImage[31], 1'b1);
    chk("no scalable image", capNoSm, 64'h0008460200000000);
    $display("test caps done");
    // register reads, writes dropped, unmapped place
    wr(rec_pkg::CAP_HI_OFS, 32'hffffffff);
    wr(rec_pkg::CAP_LO_OFS, 32'h00000000);
    rd(rec_pkg::CAP_HI_OFS, rdVal);
    chk("cap hi word", rdVal, 32'h0003e99c);
    rd(rec_pkg::CAP_LO_OFS, rdVal);
    chk("cap lo word", rdVal, 32'h80000000);
    @(posedge clk_sys);
    #1;
    chk("read idle", regRdData, 32'h0);
    rd(8'h40, rdVal);
    chk("unmapped", rdVal, 32'h0);
    $display("test regs done");
    // requests: pasid at size limit, then one bit over
    req(1'b1, 24'h0fffff, 24'h00a5a5, rec_pkg::XLATE_FIRST, 1'b1, 1'b1, 1'b1);
    chk("rsp valid", rspValid, 1'b1);
    chk("pasid ok", rspPasidErr, 1'b0);
    chk("first type", rspXlateErr, 1'b0);
    chk("super ok", rspSuperErr, 1'b0);
    chk("no write", rspNoWrite, DT);
    chk("walk snoop", rspWalkSnoop, 1'b1);
    chk("def pasid", rspDefaultPasid, 24'h00a5a5);
    req(1'b1, 24'h100000, 24'h005a5a, rec_pkg::XLATE_SECOND, 1'b0, 1'b0, 1'b0);
    chk("pasid wide", rspPasidErr, 1'b1);
    chk("second type", rspXlateErr, 1'b0);
    chk("walk off", rspWalkSnoop, 1'b0);
    chk("def pasid 2", rspDefaultPasid, 24'h005a5a);
    @(posedge clk_sys);
    #1;
    chk("rsp ends", {rspValid, rspPasidErr}, 2'h0);
    $display("test requests done");
    // status and counters after one clean and one oversize request
    rd(rec_pkg::STAT_OFS, rdVal);
    chk("status", rdVal, 32'h1);
    rd(rec_pkg::ERRCNT_OFS, rdVal);
    chk("error count", rdVal, 32'h1);
    rd(rec_pkg::REQCNT_OFS, rdVal);
    chk("request count", rdVal, 32'h2);
    wr(rec_pkg::STAT_OFS, 32'h7);
    wr(rec_pkg::CTRL_OFS, 32'h0);
    req(1'b1, 24'h100000, 24'h000000, rec_pkg::XLATE_FIRST, 1'b0, 1'b0, 1'b0);
    chk("pasid err masked", rspPasidErr, 1'b0);
    rd(rec_pkg::STAT_OFS, rdVal);
    chk("status cleared", rdVal, 32'h0);
    rd(rec_pkg::ERRCNT_OFS, rdVal);
    chk("error count held", rdVal, 32'h1);
    rd(rec_pkg::CTRL_OFS, rdVal);
    chk("ctrl", rdVal, 32'h0);
    $display("test status done");
    test_done;
  end
endmodule
`default_nettype wire
